// ---- design/asr_readout.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "asr_defines.svh"

module asr_readout
	import asr_pkg::*;
#(
	parameter int CONV60_CYC = `ASR_CONV60_CYC,
	parameter int CONV50_CYC = `ASR_CONV50_CYC,
	parameter int EXT_CONV_PERIODS = `ASR_EXT_CONV_PERIODS,
	parameter int OSC_TIMEOUT_CYC = `ASR_OSC_TIMEOUT_CYC,
	parameter int TICK_CYC = `ASR_TICK_CYC,
	parameter int FIFO_DEPTH = 16
)
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// chip select, active low
	input wire logic i_cs_n,
	// serial clock pin
	input wire logic i_sck_in,
	output logic o_sck_out,
	output logic o_sck_oe,
	output logic o_sck_pullup,
	// serial data pin
	output logic o_sdo_out,
	output logic o_sdo_oe,
	// rejection select: level or external oscillator
	input wire logic i_rejection_select,
	// results from the filter
	input wire logic i_result_valid,
	input wire logic [`ASR_DATA_BITS-1:0] i_result_data,
	output logic o_result_ready
);

	asr_regs_t s_r;
	asr_regs_t s_nxt;
	logic fifo_valid;
	logic fifo_pop;
	logic [`ASR_DATA_BITS-1:0] fifo_data;
	logic cs_fall;
	logic rs_rise;
	logic conv_tick;
	logic gen_on;
	logic sck_rise;
	logic sck_fall;
	logic conv_hit;
	logic [23:0] conv_target;

	// results wait here until a conversion ends
	asr_fifo #(
		.WIDTH(`ASR_DATA_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_in_valid(i_result_valid),
		.i_in_data(i_result_data),
		.o_in_ready(o_result_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// edges of the pins, all inputs already synchronous
	assign cs_fall = s_r.cs_q & ~i_cs_n;
	assign rs_rise = ~s_r.rs_q & i_rejection_select;

	// clock pin driven only after the select fall cycle has sampled it
	assign o_sck_oe = s_r.mode_int & ~i_cs_n & ~s_r.cs_q;
	// pull-up stays on whenever the pin is not driven
	assign o_sck_pullup = ~o_sck_oe;
	assign o_sck_out = s_r.sck_r;
	assign o_sdo_oe = ~i_cs_n;
	assign o_sdo_out = s_r.sdo;

	// generator runs while selected and sleeping or shifting
	assign gen_on = o_sck_oe &&
		(s_r.state == ASR_SLEEP || s_r.state == ASR_DOUT);

	// conversion clock: oscillator edges or internal divider
	assign conv_tick = s_r.ext_osc ? rs_rise :
		(s_r.tick_cnt == 10'(TICK_CYC - 1));

	// serial clock edges, from own generator or from the pin
	always_comb
	begin
		if (s_r.mode_int)
		begin
			sck_rise = gen_on && conv_tick && s_r.div_cnt == 2'h3 &&
				!s_r.sck_r;
			sck_fall = gen_on && conv_tick && s_r.div_cnt == 2'h3 &&
				s_r.sck_r;
		end
		else
		begin
			sck_rise = ~s_r.sck_q & i_sck_in & ~i_cs_n;
			sck_fall = s_r.sck_q & ~i_sck_in & ~i_cs_n;
		end
	end

	// conversion length depends on oscillator and rejection choice
	always_comb
	begin
		if (s_r.ext_osc)
			conv_target = 24'(EXT_CONV_PERIODS - 1);
		else if (s_r.rs_q)
			conv_target = 24'(CONV50_CYC - 1);
		else
			conv_target = 24'(CONV60_CYC - 1);
	end
	assign conv_hit = (s_r.conv_cnt >= conv_target);
	// a finished conversion stalls until the filter result is in;
	// with an oscillator the last period must close before the pop
	assign fifo_pop = (s_r.state == ASR_CONVERT) && conv_hit && fifo_valid &&
		(!s_r.ext_osc || rs_rise);

	// next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.cs_q = i_cs_n;
		s_nxt.sck_q = i_sck_in;
		s_nxt.rs_q = i_rejection_select;

		// oscillator is present while edges keep coming
		if (s_r.rs_q != i_rejection_select)
		begin
			s_nxt.osc_gap = '0;
			s_nxt.ext_osc = 1'b1;
		end
		else if (s_r.osc_gap == 16'(OSC_TIMEOUT_CYC))
			s_nxt.ext_osc = 1'b0;
		else
			s_nxt.osc_gap = s_r.osc_gap + 16'h1;

		// internal conversion clock divider
		if (s_r.tick_cnt == 10'(TICK_CYC - 1))
			s_nxt.tick_cnt = '0;
		else
			s_nxt.tick_cnt = s_r.tick_cnt + 10'h1;

		// clock mode: first cycle after reset, then every select fall
		if (!s_r.started)
		begin
			s_nxt.started = 1'b1;
			s_nxt.mode_int = i_sck_in;
		end
		else if (cs_fall)
			s_nxt.mode_int = i_sck_in;

		// serial clock over eight conversion clocks, low when idle
		if (gen_on)
		begin
			if (conv_tick)
			begin
				s_nxt.div_cnt = s_r.div_cnt + 2'h1;
				if (s_r.div_cnt == 2'h3)
					s_nxt.sck_r = ~s_r.sck_r;
			end
		end
		else
		begin
			s_nxt.div_cnt = '0;
			s_nxt.sck_r = 1'b0;
		end

		case (s_r.state)
			ASR_CONVERT:
			begin
				if (!s_r.ext_osc || rs_rise)
				begin
					if (!conv_hit)
						s_nxt.conv_cnt = s_r.conv_cnt + 24'h1;
				end
				// done: load word and sleep regardless of select
				if (fifo_pop)
				begin
					s_nxt.shift = {1'b0, ~s_r.chan, fifo_data};
					s_nxt.chan = ~s_r.chan;
					s_nxt.conv_cnt = '0;
					s_nxt.state = ASR_SLEEP;
				end
			end
			ASR_SLEEP:
			begin
				// stays here while select is high
				s_nxt.bit_cnt = '0;
				if (sck_rise && !i_cs_n)
					s_nxt.state = ASR_DOUT;
			end
			ASR_DOUT:
			begin
				if (i_cs_n)
				begin
					s_nxt.state = ASR_CONVERT;
					s_nxt.conv_cnt = '0;
				end
				else if (sck_fall)
				begin
					s_nxt.shift = {s_r.shift[30:0], 1'b1};
					s_nxt.bit_cnt = s_r.bit_cnt + 6'h1;
					// capped at 32 cycles in every clock mode
					if (s_r.bit_cnt == 6'(`ASR_SCK_MAX_CYCLES - 1))
					begin
						s_nxt.state = ASR_CONVERT;
						s_nxt.conv_cnt = '0;
					end
				end
			end
			default:
			begin
				s_nxt.state = ASR_CONVERT;
			end
		endcase

		// data pin: shifted bit, else active-low done status
		if (s_nxt.state == ASR_DOUT)
			s_nxt.sdo = s_nxt.shift[`ASR_BIT_STATUS];
		else
			s_nxt.sdo = (s_nxt.state == ASR_CONVERT);
	end

	// register the state; mode strap is caught after release
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_r <= '0;
			s_r.cs_q <= 1'b1;
			s_r.sdo <= `ASR_SDO_RESET;
			s_r.mode_int <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	property p_sdo_release;
		i_cs_n |-> !o_sdo_oe;
	endproperty
	a_sdo_release: assert property (p_sdo_release)
		else $error("data pin driven while deselected");

	property p_sck_ext_quiet;
		!s_r.mode_int |-> !o_sck_oe;
	endproperty
	a_sck_ext_quiet: assert property (p_sck_ext_quiet)
		else $error("clock pin driven in external mode");

	property p_mode_pick;
		(s_r.started && cs_fall) |=> (s_r.mode_int == $past(i_sck_in));
	endproperty
	a_mode_pick: assert property (p_mode_pick)
		else $error("clock mode not taken from pin level");

	property p_status;
		(s_r.state != ASR_DOUT) |-> (o_sdo_out == (s_r.state == ASR_CONVERT));
	endproperty
	a_status: assert property (p_status)
		else $error("status bit does not match state");

	property p_shift_bit;
		(s_r.state == ASR_DOUT && !i_cs_n && sck_fall &&
			s_r.bit_cnt != 6'h1f) |=> (o_sdo_out == $past(s_r.shift[30]));
	endproperty
	a_shift_bit: assert property (p_shift_bit)
		else $error("next bit not presented on clock fall");

	property p_enter_dout;
		(s_r.state == ASR_SLEEP && sck_rise && !i_cs_n) |=>
			(s_r.state == ASR_DOUT);
	endproperty
	a_enter_dout: assert property (p_enter_dout)
		else $error("clock rise did not start output");

	property p_abort;
		(s_r.state == ASR_DOUT && i_cs_n) |=>
			(s_r.state == ASR_CONVERT && s_r.conv_cnt == '0);
	endproperty
	a_abort: assert property (p_abort)
		else $error("select rise did not restart conversion");

	property p_last_fall;
		(s_r.state == ASR_DOUT && !i_cs_n && sck_fall &&
			s_r.bit_cnt == 6'h1f) |=> (s_r.state == ASR_CONVERT && o_sdo_out);
	endproperty
	a_last_fall: assert property (p_last_fall)
		else $error("32nd fall did not start conversion");

	property p_sleep_hold;
		(s_r.state == ASR_SLEEP && i_cs_n) |=> (s_r.state == ASR_SLEEP);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("left sleep while deselected");

	property p_bit_cap;
		(s_r.state == ASR_DOUT) |-> (s_r.bit_cnt < 6'h20);
	endproperty
	a_bit_cap: assert property (p_bit_cap)
		else $error("output ran beyond 32 clocks");

endmodule

`default_nettype wire

// ---- common/asr_defines.svh ----
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// clock
`define ASR_CLK_PERIOD_NS 10
`define ASR_CLK_HZ 100000000

// output word layout
`define ASR_WORD_BITS 32
`define ASR_BIT_STATUS 31
`define ASR_BIT_CHAN 30
`define ASR_BIT_SIGN 29
`define ASR_RES_MSB 28
`define ASR_RES_LSB 5
`define ASR_DATA_BITS 30

// serial clock and conversion timing
`define ASR_SCK_DIV 8
`define ASR_SCK_MAX_CYCLES 32
`define ASR_CONV60_MS 133
`define ASR_CONV50_MS 160
`define ASR_EXT_CONV_PERIODS 20510
`define ASR_NOTCH_DIV 2560
`define ASR_DOUT_MAX_US 1670
`define ASR_EXT_OSC_MIN_HZ 2560

// derived cycle counts
`define ASR_CONV60_CYC (`ASR_CONV60_MS * 1000000 / `ASR_CLK_PERIOD_NS)
`define ASR_CONV50_CYC (`ASR_CONV50_MS * 1000000 / `ASR_CLK_PERIOD_NS)
`define ASR_TICK_CYC (`ASR_DOUT_MAX_US * 1000 / (`ASR_CLK_PERIOD_NS * \
	`ASR_SCK_MAX_CYCLES * `ASR_SCK_DIV))
`define ASR_OSC_TIMEOUT_CYC (`ASR_CLK_HZ / `ASR_EXT_OSC_MIN_HZ)

// reset values
`define ASR_SDO_RESET 1'b1

`endif

// ---- common/asr_pkg.sv ----
package asr_pkg;

	// converter states
	typedef enum logic [1:0] {
		ASR_CONVERT = 2'b00,
		ASR_SLEEP = 2'b01,
		ASR_DOUT = 2'b10
	} asr_state_t;

	// whole state of the readout block
	typedef struct packed {
		asr_state_t state;
		logic started;
		logic mode_int;
		logic cs_q;
		logic sck_q;
		logic rs_q;
		logic ext_osc;
		logic [15:0] osc_gap;
		logic [23:0] conv_cnt;
		logic [9:0] tick_cnt;
		logic [1:0] div_cnt;
		logic sck_r;
		logic [5:0] bit_cnt;
		logic [31:0] shift;
		logic chan;
		logic sdo;
	} asr_regs_t;

endpackage

// ---- design/asr_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module asr_fifo
	import asr_pkg::*;
#(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
)
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// fill side
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// drain side
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} asr_fifo_regs_t;

	asr_fifo_regs_t s_r;
	asr_fifo_regs_t s_nxt;
	logic push;
	logic pop;

	// honest flags straight from the fill count
	assign o_in_ready = (s_r.count != (AW + 1)'(DEPTH));
	assign o_out_valid = (s_r.count != '0);
	assign o_out_data = s_r.mem[s_r.rd];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// pointers wrap by index; depth need not be a power of two
	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wr] = i_in_data;
			s_nxt.wr = (s_r.wr == AW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
		end
		if (pop)
			s_nxt.rd = (s_r.rd == AW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
		s_nxt.count = s_r.count + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// register the state
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

endmodule

`default_nettype wire

// ---- sim/asr_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module asr_host_model
(
	// clock
	input wire logic i_clock,
	// pins seen from the device
	input wire logic i_sck_out,
	input wire logic i_sck_oe,
	input wire logic i_sck_pullup,
	input wire logic i_sdo_out,
	input wire logic i_sdo_oe,
	// pins driven toward the device
	output logic o_cs_n,
	output logic o_sck
);
	logic sck_drv = 1'b0;
	logic sck_en = 1'b1;
	logic sck_last = 1'b0;
	logic sdo_line;

	initial o_cs_n = 1'b1;

	// resolved clock wire; floating with no pull-up flips each cycle
	assign o_sck = i_sck_oe ? i_sck_out : sck_en ? sck_drv :
		i_sck_pullup ? 1'b1 : ~sck_last;

	// released data wire shows junk, never a stale valid bit
	assign sdo_line = i_sdo_oe ? i_sdo_out : ~i_sdo_out;

	// last wire level, used only for the floating case
	always @(posedge i_clock)
		sck_last <= o_sck;

	// count clocks until the status line drops, bounded
	task automatic wait_done(output int n);
		n = 0;
		while (sdo_line !== 1'b0 && n < 2000)
			@(posedge i_clock) #1 n++;
	endtask

	// 32 clocks, three cycles per phase; bit read just before each rise
	task automatic read_word(output logic [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			repeat (3) @(posedge i_clock);
			#1 w[i] = sdo_line;
			sck_drv = 1'b1;
			repeat (3) @(posedge i_clock);
			#1 sck_drv = 1'b0;
		end
		repeat (3) @(posedge i_clock);
	endtask
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "asr_defines.svh"

module testbench;
	localparam int C60 = 200;
	localparam int C50 = 300;
	localparam int TICK = 4;
	localparam int EXT = 20;

	typedef struct packed {
		logic rs;
		logic [29:0] data;
	} asr_row_t;

	// short conversions so the whole run stays small
	asr_row_t rows [4] = '{'{1'b0, 30'h1000_0001}, '{1'b1, 30'h0f0f_0f0f},
		'{1'b1, 30'h1555_5555}, '{1'b0, 30'h0aaa_aaaa}};
	logic clk, arst_n, cs_n, sck, sck_out, sck_oe, sck_pu, sdo, sdo_oe;
	logic rs, valid, ready;
	logic [29:0] data;
	int err_total = 0;
	int checks = 0;

	asr_readout #(.CONV60_CYC(C60), .CONV50_CYC(C50),
		.EXT_CONV_PERIODS(EXT), .OSC_TIMEOUT_CYC(50), .TICK_CYC(TICK),
		.FIFO_DEPTH(16)) uut (.i_clock(clk), .i_arst_n(arst_n),
		.i_cs_n(cs_n), .i_sck_in(sck), .o_sck_out(sck_out),
		.o_sck_oe(sck_oe), .o_sck_pullup(sck_pu), .o_sdo_out(sdo),
		.o_sdo_oe(sdo_oe), .i_rejection_select(rs),
		.i_result_valid(valid), .i_result_data(data),
		.o_result_ready(ready));

	asr_host_model host (.i_clock(clk), .i_sck_out(sck_out),
		.i_sck_oe(sck_oe), .i_sck_pullup(sck_pu), .i_sdo_out(sdo),
		.i_sdo_oe(sdo_oe), .o_cs_n(cs_n), .o_sck(sck));

	task automatic check_word(string name, logic [31:0] exp,
		logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_range(string name, int lo, int hi, int got);
		checks++;
		if (got < lo || got > hi)
		begin
			err_total++;
			$display("mismatch %s expected %0d..%0d seen %0d", name, lo,
				hi, got);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog well beyond the expected few thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop();
	end

	initial
	begin
		logic [31:0] w;
		int n;
		int t;
		arst_n = 1'b0;
		rs = 1'b0;
		valid = 1'b0;
		data = '0;
		repeat (12) @(posedge clk);
		#1 check_word("reset sdo", 1, sdo);
		check_word("reset sck oe", 0, sck_oe);
		check_word("reset pullup", 1, sck_pu);
		check_word("reset ready", 1, ready);
		arst_n = 1'b1;
		repeat (2) @(posedge clk);
		// fill the buffer back to back until it refuses
		for (int i = 0; i < 16; i++)
		begin
			#1 valid = 1'b1;
			data = (i < 4) ? rows[i].data : 30'(i);
			@(posedge clk);
		end
		#1 check_word("ready when full", 0, ready);
		valid = 1'b0;
		check_word("sdo oe cs high", 0, sdo_oe);
		// clock held low at select fall: external mode, status busy
		host.o_cs_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check_word("sck oe external", 0, sck_oe);
		check_word("pullup external", 1, sck_pu);
		check_word("status busy", 1, sdo);
		// select stays low: back to back conversions and readouts
		for (int i = 0; i < 4; i++)
		begin
			host.wait_done(n);
			t = (i > 0 && rows[i - 1].rs) ? C50 : C60;
			if (i > 0)
				check_range("conv time", t - 8, t + 4, n);
			rs = rows[i].rs;
			host.read_word(w);
			check_word("word", {1'b0, ~i[0], rows[i].data}, w);
			#1 check_word("sdo after 32", 1, sdo);
		end
		host.o_cs_n = 1'b1;
		@(posedge clk);
		#1 check_word("sdo oe released", 0, sdo_oe);
		// release the clock pin, let the conversion end into sleep
		host.sck_en = 1'b0;
		repeat (350) @(posedge clk);
		#1 host.o_cs_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check_word("sck oe internal", 1, sck_oe);
		check_word("pullup internal", 0, sck_pu);
		check_word("status sleep", 0, sdo);
		n = 0;
		while (sck_out !== 1'b1 && n < 100)
			@(posedge clk) #1 n++;
		n = 0;
		while (sck_out === 1'b1 && n < 100)
			@(posedge clk) #1 n++;
		check_range("sck high time", 4 * TICK, 4 * TICK, n);
		// abort mid transfer, then watch a full fresh conversion
		host.o_cs_n = 1'b1;
		repeat (2) @(posedge clk);
		#1 host.o_cs_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 check_word("status after abort", 1, sdo);
		host.wait_done(n);
		check_range("abort conv", C60 - 10, C60 + 4, n);
		// external clock again, next conversion paced by an oscillator
		host.o_cs_n = 1'b1;
		host.sck_en = 1'b1;
		repeat (2) @(posedge clk);
		#1 host.o_cs_n = 1'b0;
		repeat (2) @(posedge clk);
		fork
			repeat (100)
			begin
				repeat (4) @(posedge clk);
				#1 rs = ~rs;
			end
			begin
				host.read_word(w);
				check_word("ext word", 32'h0000_0005, w);
				host.wait_done(n);
				check_range("ext conv", 8 * EXT - 9, 8 * EXT - 2, n);
			end
		join
		// reset in mid-run with select low: strap again, buffer empty
		arst_n = 1'b0;
		#1 check_word("mid reset sdo", 1, sdo);
		repeat (2) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (C60 + 20) @(posedge clk);
		#1 check_word("mid reset oe", 0, sck_oe);
		check_word("stall no result", 1, sdo);
		report_and_stop();
	end
endmodule

`default_nettype wire
